// >>> trim_regs_pkg.sv
/*
 * Shared constants and carrier types for the bank trim and timestamp register bank.
 * Assumes a 32-bit Avalon-MM master with byte addressing; each register sits in the
 * low byte of one aligned word at four times its register index.
 */
package trim_regs_pkg;

   // Widths of the data paths.
   localparam int SAMPLE_W = 8;
   localparam int TRIM_W   = 8;
   localparam int DATA_W   = 32;
   localparam int ADDR_W   = 12;
   localparam int IDX_W    = 10;
   localparam int CS_W     = 2;

   // Register indices; the byte address is four times the index.
   localparam logic [IDX_W-1:0] IDX_B4_QUAD  = 10'h143;
   localparam logic [IDX_W-1:0] IDX_B5_INPH  = 10'h152;
   localparam logic [IDX_W-1:0] IDX_B5_QUAD  = 10'h153;
   localparam logic [IDX_W-1:0] IDX_LSB_CTRL = 10'h160;
   localparam logic [IDX_W-1:0] IDX_CONFIG   = 10'h170;
   localparam logic [IDX_W-1:0] IDX_STATUS   = 10'h171;

   // Field positions.
   localparam int TS_EN_BIT      = 0;
   localparam int CFG_PHASE_BIT  = 0;
   localparam int CFG_CAL_BIT    = 1;
   localparam int CFG_RECV_BIT   = 2;
   localparam int STAT_TS_BIT    = 0;
   localparam int STAT_CAL_BIT   = 1;
   localparam int STAT_LSB_BIT   = 2;

   // Reset values.
   localparam logic [7:0]      LSB_CTRL_RST = 8'h00;
   localparam logic [7:0]      CONFIG_RST   = 8'h00;
   localparam logic [TRIM_W-1:0] FACTORY_TRIM_DEF = 8'h80; // Arbitrary neutral value.
   localparam logic [CS_W-1:0] ILA_CS_BITS  = 2'h0;

   // Avalon-MM request from the master.
   typedef struct packed {
      logic [ADDR_W-1:0]   address;
      logic                read;
      logic                write;
      logic [DATA_W-1:0]   writedata;
      logic [DATA_W/8-1:0] byteenable;
   } avm_req_t;

   // Avalon-MM answer to the master.
   typedef struct packed {
      logic [DATA_W-1:0] readdata;
      logic              waitrequest;
   } avm_rsp_t;

   // One converter sample with its side-band bits, all of the same instant.
   typedef struct packed {
      logic [SAMPLE_W-1:0] data;
      logic                marker;
      logic                cal_state;
   } sample_in_t;

   // Register index from a byte address.
   function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
      return addr[ADDR_W-1:2];
   endfunction

endpackage

// >>> bank_trim_and_timestamp_regs.sv
/*
 * Register bank for per-bank sampling-time trims and the sample LSB timestamp marker,
 * with the sample path that inserts the marker and the trim selection per clock phase.
 * Assumes one clock, a synchronous active-high reset, inputs synchronous to the clock,
 * and software as the only party on the Avalon-MM side.
 */
// Chosen here: register access over Avalon-MM.
// What this block does
// - Bank four quadrature trim used at minus ninety.
// - Bank five in-phase trim used at zero degrees.
// - Bank five quadrature trim used at minus ninety.
// - Trims reset to factory values, readable and writable.
// - With receiver enabled, timestamp enable puts marker in every sample LSB.
// - Marker delayed exactly like its sample.
// - Lane alignment always reports zero control bits.
// - LSB control register resets to all zeros.
`timescale 1ns/1ps
module bank_trim_and_timestamp_regs
   import trim_regs_pkg::*;
#(
   parameter int                 LATENCY      = 4,
   parameter logic [TRIM_W-1:0]  FACTORY_B4_Q = FACTORY_TRIM_DEF,
   parameter logic [TRIM_W-1:0]  FACTORY_B5_I = FACTORY_TRIM_DEF,
   parameter logic [TRIM_W-1:0]  FACTORY_B5_Q = FACTORY_TRIM_DEF
)
(
   input  wire logic                         clk_sys_i,
   input  wire logic                         rst_i,
   input  wire trim_regs_pkg::avm_req_t      avm_i,
   output trim_regs_pkg::avm_rsp_t           avm_o,
   input  wire trim_regs_pkg::sample_in_t    sample_i,
   output logic [trim_regs_pkg::SAMPLE_W-1:0] sample_o,
   output logic [trim_regs_pkg::TRIM_W-1:0]  bank4_trim_o,
   output logic                              bank4_trim_apply_o,
   output logic [trim_regs_pkg::TRIM_W-1:0]  bank5_trim_o,
   output logic                              marker_input_receiver_enable_o,
   output logic [trim_regs_pkg::CS_W-1:0]    ila_cs_bits_o
);
   import trim_regs_pkg::*;

   localparam int PIPE_LAT = LATENCY;

   // Whole state of the block in one record.
   typedef struct packed {
      logic [TRIM_W-1:0]                b4_quad;
      logic [TRIM_W-1:0]                b5_inph;
      logic [TRIM_W-1:0]                b5_quad;
      logic [7:0]                       lsb_ctrl;
      logic [7:0]                       config_r;
      logic                             wait_r;
      logic [DATA_W-1:0]                rdata;
      logic [LATENCY-1:0][SAMPLE_W-1:0] pipe;
      logic [TRIM_W-1:0]                b4_out;
      logic                             b4_apply;
      logic [TRIM_W-1:0]                b5_out;
      logic                             recv_en;
      logic [CS_W-1:0]                  cs_bits;
   } state_t;

   state_t st_reg;
   state_t st_next;

   logic              req;
   logic              ack;
   logic [IDX_W-1:0]  idx;
   logic              phase_quad;
   logic              ts_en;
   logic              cal_en;
   logic              lsb_sel;
   logic [7:0]        status;

   // Request decode; the answer comes one cycle after the request is first seen.
   assign req        = avm_i.read | avm_i.write;
   assign ack        = req & ~st_reg.wait_r;
   assign idx        = reg_index(avm_i.address);
   assign phase_quad = st_reg.config_r[CFG_PHASE_BIT];
   assign ts_en      = st_reg.lsb_ctrl[TS_EN_BIT];
   assign cal_en     = st_reg.config_r[CFG_CAL_BIT];

   // Timestamp takes priority over calibration state; the marker only passes when
   // its receiver is enabled, so enabling insertion alone yields a zero LSB.
   always_comb
   begin
      if (ts_en)
      begin
         lsb_sel = sample_i.marker & st_reg.config_r[CFG_RECV_BIT];
      end
      else if (cal_en)
      begin
         lsb_sel = sample_i.cal_state;
      end
      else
      begin
         lsb_sel = sample_i.data[0];
      end
   end

   // Status word shows which source currently feeds the LSB and the last LSB sent.
   always_comb
   begin
      status                = 8'h00;
      status[STAT_TS_BIT]   = ts_en;
      status[STAT_CAL_BIT]  = cal_en & ~ts_en;
      status[STAT_LSB_BIT]  = st_reg.pipe[LATENCY-1][0];
   end

   // Next-state logic: bus slave, register writes, sample pipe and trim outputs.
   always_comb
   begin
      st_next         = st_reg;
      st_next.wait_r  = ~(req & st_reg.wait_r);
      if (req & st_reg.wait_r)
      begin
         // Read data is latched at the first edge so it stands while waitrequest is low.
         st_next.rdata = '0;
         case (idx)
            IDX_B4_QUAD:  st_next.rdata[TRIM_W-1:0] = st_reg.b4_quad;
            IDX_B5_INPH:  st_next.rdata[TRIM_W-1:0] = st_reg.b5_inph;
            IDX_B5_QUAD:  st_next.rdata[TRIM_W-1:0] = st_reg.b5_quad;
            IDX_LSB_CTRL: st_next.rdata[7:0]        = st_reg.lsb_ctrl;
            IDX_CONFIG:   st_next.rdata[7:0]        = st_reg.config_r;
            IDX_STATUS:   st_next.rdata[7:0]        = status;
            default:      st_next.rdata             = '0;
         endcase
      end
      // Writes land at the edge where waitrequest is seen low; only lane 0 carries data.
      if (ack & avm_i.write & avm_i.byteenable[0])
      begin
         case (idx)
            IDX_B4_QUAD:  st_next.b4_quad  = avm_i.writedata[TRIM_W-1:0];
            IDX_B5_INPH:  st_next.b5_inph  = avm_i.writedata[TRIM_W-1:0];
            IDX_B5_QUAD:  st_next.b5_quad  = avm_i.writedata[TRIM_W-1:0];
            IDX_LSB_CTRL: st_next.lsb_ctrl = avm_i.writedata[7:0];
            IDX_CONFIG:   st_next.config_r = avm_i.writedata[7:0];
            default:      st_next.lsb_ctrl = st_reg.lsb_ctrl;
         endcase
      end
      // The marker rides in the sample word itself, so every stage delays both alike.
      st_next.pipe[0] = {sample_i.data[SAMPLE_W-1:1], lsb_sel};
      for (int i = 1; i < LATENCY; i++)
      begin
         st_next.pipe[i] = st_reg.pipe[i-1];
      end
      // Trims follow the registers every cycle, no reset needed after a change.
      st_next.b4_out   = st_reg.b4_quad;
      st_next.b4_apply = phase_quad;
      st_next.b5_out   = phase_quad ? st_reg.b5_quad : st_reg.b5_inph;
      st_next.recv_en  = st_reg.config_r[CFG_RECV_BIT];
      st_next.cs_bits  = ILA_CS_BITS;
   end

   // State register with its reset values; trims come back holding factory values.
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         st_reg          <= '0;
         st_reg.b4_quad  <= FACTORY_B4_Q;
         st_reg.b5_inph  <= FACTORY_B5_I;
         st_reg.b5_quad  <= FACTORY_B5_Q;
         st_reg.lsb_ctrl <= LSB_CTRL_RST;
         st_reg.config_r <= CONFIG_RST;
         st_reg.wait_r   <= 1'b1;
         st_reg.cs_bits  <= ILA_CS_BITS;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state record.
   assign avm_o.readdata               = st_reg.rdata;
   assign avm_o.waitrequest            = st_reg.wait_r;
   assign sample_o                     = st_reg.pipe[LATENCY-1];
   assign bank4_trim_o                 = st_reg.b4_out;
   assign bank4_trim_apply_o           = st_reg.b4_apply;
   assign bank5_trim_o                 = st_reg.b5_out;
   assign marker_input_receiver_enable_o = st_reg.recv_en;
   assign ila_cs_bits_o                = st_reg.cs_bits;

   // Properties share one clock and are held off while reset is high.
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   // Handshake steps of one bus access: a fresh request, then one cycle of answer.
   sequence new_request_s;
      req && avm_o.waitrequest;
   endsequence

   sequence one_cycle_answer_s;
      !avm_o.waitrequest ##1 avm_o.waitrequest;
   endsequence

   // Fresh reads of the registers whose read path is checked below.
   sequence trim_read_s;
      new_request_s ##0 (avm_i.read && idx == IDX_B5_QUAD);
   endsequence

   sequence lsb_read_s;
      new_request_s ##0 (avm_i.read && idx == IDX_LSB_CTRL);
   endsequence

   sequence status_read_s;
      new_request_s ##0 (avm_i.read && idx == IDX_STATUS);
   endsequence

   // A write that lands at this edge with its data lane enabled.
   sequence write_lands_s;
      ack && avm_i.write && avm_i.byteenable[0];
   endsequence

   bus_handshake_a: assert property (new_request_s |=> one_cycle_answer_s)
      else $error("Waitrequest did not drop for exactly one cycle.");

   unmapped_read_zero_a: assert property (
      new_request_s ##0 (avm_i.read && idx == 10'h161)
      |=> avm_o.readdata == 32'h0000_0000)
      else $error("Unmapped read returned nonzero data.");

   // Read data is latched from the register as it stood at the first edge.
   trim_read_back_a: assert property (
      trim_read_s |=> avm_o.readdata == {24'h00_0000, $past(st_reg.b5_quad)})
      else $error("Trim read returned the wrong value.");

   trim_write_lands_a: assert property (
      (write_lands_s ##0 (idx == IDX_B5_INPH))
      |=> st_reg.b5_inph == $past(avm_i.writedata[TRIM_W-1:0]))
      else $error("Trim write did not take effect.");

   lsb_write_lands_a: assert property (
      (write_lands_s ##0 (idx == IDX_LSB_CTRL))
      |=> st_reg.lsb_ctrl == $past(avm_i.writedata[7:0]))
      else $error("LSB control write did not take effect.");

   lsb_read_back_a: assert property (
      lsb_read_s |=> avm_o.readdata == {24'h00_0000, $past(st_reg.lsb_ctrl)})
      else $error("LSB control read returned the wrong value.");

   // Reset values are checked at the first edge with reset low, so the
   // general disable must not apply to these three.
   lsb_reset_zero_a: assert property (
      disable iff (1'b0) $fell(rst_i) |-> st_reg.lsb_ctrl == 8'h00)
      else $error("LSB control register not zero after reset.");

   trim_factory_reset_a: assert property (
      disable iff (1'b0) $fell(rst_i) |-> st_reg.b5_quad == FACTORY_B5_Q)
      else $error("Trim did not reset to its factory value.");

   bus_idle_reset_a: assert property (
      disable iff (1'b0) $fell(rst_i) |-> avm_o.waitrequest)
      else $error("Bus answered straight out of reset.");

   // The output trim follows the register of the selected phase one edge later.
   bank5_phase_sel_a: assert property (
      phase_quad |=> bank5_trim_o == $past(st_reg.b5_quad))
      else $error("Bank five quadrature trim not applied.");

   bank5_inphase_sel_a: assert property (
      !phase_quad |=> bank5_trim_o == $past(st_reg.b5_inph))
      else $error("Bank five in-phase trim not applied.");

   bank4_apply_a: assert property (
      phase_quad |=> bank4_trim_apply_o && bank4_trim_o == $past(st_reg.b4_quad))
      else $error("Bank four quadrature trim not applied.");

   // Bank four's zero-degree trim lives elsewhere, so this trim must stand aside.
   bank4_idle_a: assert property (
      !phase_quad |=> !bank4_trim_apply_o)
      else $error("Bank four quadrature trim applied at zero degrees.");

   // A new quadrature value reaches the bank without any reset in between.
   trim_live_change_a: assert property (
      (write_lands_s ##0 (idx == IDX_B5_QUAD && phase_quad) ##1 phase_quad)
      |=> bank5_trim_o == $past(avm_i.writedata[TRIM_W-1:0], 2))
      else $error("Trim change did not reach the bank.");

   ila_cs_zero_a: assert property (ila_cs_bits_o == 2'h0)
      else $error("Lane alignment reports control bits.");

   recv_enable_copy_a: assert property (
      1'b1 |=> marker_input_receiver_enable_o == $past(st_reg.config_r[CFG_RECV_BIT]))
      else $error("Marker receiver enable does not follow its control bit.");

   // The whole sample word, marker included, leaves exactly PIPE_LAT edges later.
   marker_aligned_a: assert property (
      (ts_en && st_reg.config_r[CFG_RECV_BIT])
      |-> ##PIPE_LAT sample_o == $past({sample_i.data[SAMPLE_W-1:1], sample_i.marker},
                                       PIPE_LAT))
      else $error("Marker not aligned with its sample.");

   upper_bits_kept_a: assert property (
      1'b1 |-> ##PIPE_LAT sample_o[SAMPLE_W-1:1]
               == $past(sample_i.data[SAMPLE_W-1:1], PIPE_LAT))
      else $error("Upper sample bits changed on the way through.");

   marker_in_lsb_a: assert property (
      (ts_en && st_reg.config_r[CFG_RECV_BIT] && sample_i.marker) |-> ##PIPE_LAT sample_o[0])
      else $error("Timestamp marker missing from the sample LSB.");

   // With the receiver off the marker reads as zero, yet still displaces other sources.
   marker_gated_a: assert property (
      (ts_en && !st_reg.config_r[CFG_RECV_BIT]) |-> ##PIPE_LAT !sample_o[0])
      else $error("Disabled marker receiver let a one through.");

   ts_priority_a: assert property (
      (ts_en && cal_en && st_reg.config_r[CFG_RECV_BIT] && sample_i.marker
       && !sample_i.cal_state) |-> ##PIPE_LAT sample_o[0])
      else $error("Calibration state displaced the timestamp.");

   cal_state_lsb_a: assert property (
      (!ts_en && cal_en) |-> ##PIPE_LAT sample_o[0] == $past(sample_i.cal_state, PIPE_LAT))
      else $error("Calibration state not placed in the sample LSB.");

   status_source_a: assert property (
      status_read_s |=> avm_o.readdata[1:0] == $past({cal_en & ~ts_en, ts_en}))
      else $error("Status does not show the LSB source.");

endmodule // bank_trim_and_timestamp_regs

// >>> test_bank_trim_and_timestamp_regs.sv
/* Self-checking bench for the bank trim and timestamp register bank.
   Assumes trim_regs_pkg and the design module are compiled before it. */
`timescale 1ns/1ps
module test_bank_trim_and_timestamp_regs;
   import trim_regs_pkg::*;
   localparam int LAT = 3; // Shorter than the default so that a wrong depth shows.
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0]  rstv;
      logic [7:0]  wv;
      logic [7:0]  rv;
   } row_t;
   logic       clk_sys_i = 1'b0;
   logic       rst_i     = 1'b1;
   avm_req_t   avm_i     = '0;
   avm_rsp_t   avm_o;
   sample_in_t sample_i  = '0;
   logic [7:0] sample_o, b4_trim, b5_trim, expv, m;
   logic       b4_apply, recv_en;
   logic [1:0] cs_bits;
   logic [31:0] rd;
   int         n_errors = 0;
   int         n_tests  = 0;
   row_t       rows [7];
   sample_in_t hist [12];
   logic [7:0] modes [5];

   // Free-running clock, half period 4 ns.
   always #4 clk_sys_i = ~clk_sys_i;

   bank_trim_and_timestamp_regs #(.LATENCY(LAT)) dut_u (
      .clk_sys_i                      (clk_sys_i),
      .rst_i                          (rst_i),
      .avm_i                          (avm_i),
      .avm_o                          (avm_o),
      .sample_i                       (sample_i),
      .sample_o                       (sample_o),
      .bank4_trim_o                   (b4_trim),
      .bank4_trim_apply_o             (b4_apply),
      .bank5_trim_o                   (b5_trim),
      .marker_input_receiver_enable_o (recv_en),
      .ila_cs_bits_o                  (cs_bits)
   );

   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want)
      begin
         n_errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
      end
   endtask

   // One Avalon access; holds the request until waitrequest is sampled low.
   task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int k;
      k = 0;
      avm_i.address    <= a;
      avm_i.write      <= wr;
      avm_i.read       <= ~wr;
      avm_i.writedata  <= {24'h000000, d};
      avm_i.byteenable <= 4'hF;
      do
      begin
         @(posedge clk_sys_i);
         k++;
      end while (avm_o.waitrequest !== 1'b0 && k < 50);
      if (k >= 50)
      begin
         chk(32'h0, 32'h1);
         tally_and_finish();
      end
      rd = avm_o.readdata;
      avm_i.read  <= 1'b0;
      avm_i.write <= 1'b0;
      // One idle edge keeps a following call from reassigning these in the same step.
      @(posedge clk_sys_i);
   endtask

   // Trim outputs lag the register by one edge; two more edges leave margin.
   task automatic settle();
      repeat (3) @(posedge clk_sys_i);
   endtask

   // The bench's own view of the output LSB selection.
   function automatic logic [7:0] lsb_exp(input sample_in_t h, input logic [7:0] md);
      logic b;
      b = md[3] ? (h.marker & md[2]) : (md[1] ? h.cal_state : h.data[0]);
      return {h.data[7:1], b};
   endfunction

   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Cuts a hang short; the whole run needs well under 2000 cycles.
   initial
   begin
      #100000;
      n_errors++;
      tally_and_finish();
   end

   initial
   begin
      rows[0] = '{12'h50C, 8'h80, 8'h11, 8'h11};
      rows[1] = '{12'h548, 8'h80, 8'h22, 8'h22};
      rows[2] = '{12'h54C, 8'h80, 8'h33, 8'h33};
      rows[3] = '{12'h580, 8'h00, 8'hFE, 8'hFE}; // Reserved bits are stored.
      rows[4] = '{12'h584, 8'h00, 8'h77, 8'h00}; // Unmapped word reads zero.
      rows[5] = '{12'h5C0, 8'h00, 8'h07, 8'h07}; // Configuration reads back.
      rows[6] = '{12'h5C4, 8'h00, 8'hFF, 8'h02}; // Status ignores writes.
      modes = '{8'h00, 8'h02, 8'h0C, 8'h0E, 8'h0A};
      repeat (6) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      for (int i = 0; i < 7; i++)
      begin
         bus(1'b0, rows[i].addr, 8'h00);
         chk(rd, {24'h0, rows[i].rstv});
      end
      for (int i = 0; i < 7; i++)
      begin
         bus(1'b1, rows[i].addr, rows[i].wv);
         bus(1'b0, rows[i].addr, 8'h00);
         chk(rd, {24'h0, rows[i].rv});
      end
      $display("register table test done");
      // Phase selection of the trims, then a live change at minus ninety.
      bus(1'b1, 12'h5C0, 8'h00);
      settle();
      chk(b5_trim, 8'h22);
      chk(b4_apply, 1'b0);
      bus(1'b1, 12'h5C0, 8'h01);
      settle();
      chk(b4_trim, 8'h11);
      chk(b4_apply, 1'b1);
      chk(b5_trim, 8'h33);
      bus(1'b1, 12'h54C, 8'h44);
      settle();
      chk(b5_trim, 8'h44);
      bus(1'b1, 12'h548, 8'h99);
      settle();
      chk(b5_trim, 8'h44);
      $display("trim selection test done");
      // Each LSB source mode with a stream of samples.
      for (int j = 0; j < 5; j++)
      begin
         m = modes[j];
         bus(1'b1, 12'h580, {7'h00, m[3]});
         bus(1'b1, 12'h5C0, {5'h00, m[2:0]});
         for (int i = 0; i < 12; i++)
            hist[i] = {8'(8'h35 + i * 37), i[0], i[1]};
         sample_i <= hist[0];
         for (int i = 0; i < 11; i++)
         begin
            @(posedge clk_sys_i);
            if (i >= LAT)
               chk(sample_o, lsb_exp(hist[i - LAT], m));
            sample_i <= hist[i + 1];
         end
         chk(recv_en, m[2]);
         chk(cs_bits, 2'h0);
         // Status is latched one edge after the stream ends, showing sample 11 - LAT.
         bus(1'b0, 12'h5C4, 8'h00);
         expv = lsb_exp(hist[11 - LAT], m);
         chk(rd, {29'h0, expv[0], m[1] & ~m[3], m[3]});
      end
      $display("sample lsb test done");
      // A second reset in mid-run restores the control register.
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      bus(1'b0, 12'h580, 8'h00);
      chk(rd, 32'h0);
      bus(1'b0, 12'h548, 8'h00);
      chk(rd, 32'h80);
      $display("second reset test done");
      tally_and_finish();
   end
endmodule // test_bank_trim_and_timestamp_regs
